// *** rtl/prm_register_map.sv ***
/*
  prm_register_map: paged 16-bit register map behind the serial command port.
  Assumes the serial deframer delivers whole 16-bit words as one-cycle strobes,
  and a frame-start pulse on each falling edge of the select line.
*/
// Contract
// (R1) Storage is 16-bit registers in four pages: results, two control, buffer.
// (R2) Page 0 results at 00-03, 05, 07-0A; other addresses reserved.
// (R3) All page 0 results read zero after reset until a conversion writes.
// (R4) Page 0 results are read only; host writes are ignored.
// (R5) Result words hold a 12-bit value right-justified, top four bits zero.
// (R6) Control bits may read as status and write as command.
// (R7) Page 1 control registers occupy addresses 00 through 0D.
// (R8) Page 2: coefficients 07-1A, clock synth 1B-1C, pin control 23; 28+ reserved.
// (R9) Page 3 buffer locations occupy every address 00 to 3F.
// (R10) Access starts with command: direction bit 15, page, address, five zero bits.
// (R11) Address auto-increments; reads past page end return all ones.
// (R12) Reserved addresses read zero; writes there change nothing.
`timescale 1ns/1ps
`default_nettype none
module prm_register_map
  import prm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // deframed serial port
  input wire logic frame_start_i,
  input wire logic word_valid_i,
  input wire logic [15:0] word_i,
  output logic [15:0] read_word_o,
  output logic read_valid_o,
  // converter result input
  input wire logic conv_valid_i,
  input wire logic [3:0] conv_idx_i,
  input wire logic [11:0] conv_value_i,
  // page 1 status seen on reads of control bits; page 3 buffer word and pop
  input wire logic [15:0] touch_status_i [14],
  input wire logic [15:0] buffer_word_i,
  output logic buffer_pop_o,
  // settings written to control pages
  output logic [15:0] touch_setting_o [14],
  output logic [15:0] audio_setting_o [40]
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic [3:0] prm_result_index(input logic [5:0] a);
    unique case (a)
      PRM_ADDR_HORIZONTAL: return 4'h0;
      PRM_ADDR_VERTICAL: return 4'h1;
      PRM_ADDR_PRESSURE_FIRST: return 4'h2;
      PRM_ADDR_PRESSURE_SECOND: return 4'h3;
      PRM_ADDR_BATTERY: return 4'h4;
      PRM_ADDR_AUX_ONE: return 4'h5;
      PRM_ADDR_AUX_TWO: return 4'h6;
      PRM_ADDR_TEMP_FIRST: return 4'h7;
      PRM_ADDR_TEMP_SECOND: return 4'h8;
      default: return 4'hf;
    endcase
  endfunction

  prm_state_t state_reg;
  logic [3:0] page_reg;
  logic [5:0] addr_reg;
  logic past_end_reg;
  logic [15:0] touch_reg [14];
  logic [15:0] audio_reg [40];
  logic [15:0] read_word_reg;
  logic read_valid_reg;
  logic pop_reg;

  prm_res_if res ();
  prm_result_bank u_bank (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .res(res.bank));

  // ---------------------------------------------------------------
  // result path
  // ---------------------------------------------------------------
  // only the converter port writes results; host writes never reach here
  assign res.wr_en = conv_valid_i; // R4
  assign res.wr_idx = conv_idx_i;
  assign res.wr_value = conv_value_i;

  // frame start wins: a word in the same cycle is dropped, never answered
  wire cmd_word = word_valid_i && !frame_start_i && state_reg == PRM_IDLE;
  wire data_word = word_valid_i && !frame_start_i && state_reg != PRM_IDLE;
  wire [3:0] cmd_page = word_i[PRM_CMD_PAGE_LSB +: 4]; // R10
  wire [5:0] cmd_addr = word_i[PRM_CMD_ADDR_LSB +: 6]; // R10
  wire cmd_is_read = word_i[PRM_CMD_DIR_BIT]; // R10
  // on a read command the first word out is for the commanded address
  wire [3:0] acc_page = cmd_word ? cmd_page : page_reg;
  wire [5:0] acc_addr = cmd_word ? cmd_addr : addr_reg;
  wire acc_past = cmd_word ? 1'b0 : past_end_reg;
  assign res.rd_idx = prm_result_index(acc_addr);

  wire touch_hit = acc_addr <= PRM_ADDR_TOUCH_LAST; // R7
  wire audio_hit = acc_addr <= PRM_ADDR_AUDIO_LAST; // R8
  wire page_ok = acc_page <= PRM_PAGE_BUFFER; // R1
  wire [15:0] touch_rd = touch_hit ? touch_status_i[acc_addr[3:0]] : PRM_RESERVED_READ; // R6
  wire [15:0] audio_rd = audio_hit ? audio_reg[acc_addr] : PRM_RESERVED_READ; // R12
  wire [15:0] page_rd =
      !page_ok ? PRM_RESERVED_READ :
      acc_page == PRM_PAGE_DATA ? res.rd_word : // R2
      acc_page == PRM_PAGE_TOUCH ? touch_rd :
      acc_page == PRM_PAGE_AUDIO ? audio_rd :
      buffer_word_i; // R9
  wire [15:0] rd_mux = acc_past ? PRM_PAST_END_READ : page_rd; // R11
  wire read_now = (cmd_word && cmd_is_read) || (data_word && state_reg == PRM_READ);
  wire write_now = data_word && state_reg == PRM_WRITE && !past_end_reg;
  wire write_touch = write_now && page_reg == PRM_PAGE_TOUCH && touch_hit; // R12
  wire write_audio = write_now && page_reg == PRM_PAGE_AUDIO && audio_hit; // R12
  wire at_last = acc_addr == PRM_ADDR_PAGE_LAST;

  // ---------------------------------------------------------------
  // transfer sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= PRM_IDLE;
      page_reg <= 4'h0;
      addr_reg <= 6'h00;
      past_end_reg <= 1'b0;
    end else if (frame_start_i) begin
      state_reg <= PRM_IDLE;
      past_end_reg <= 1'b0;
    end else if (cmd_word) begin
      state_reg <= cmd_is_read ? PRM_READ : PRM_WRITE;
      page_reg <= cmd_page;
      // a read has already consumed the commanded location
      addr_reg <= cmd_is_read ? cmd_addr + 6'h01 : cmd_addr;
      past_end_reg <= cmd_is_read && cmd_addr == PRM_ADDR_PAGE_LAST;
    end else if (data_word) begin
      addr_reg <= addr_reg + 6'h01; // R11
      past_end_reg <= past_end_reg || at_last; // R11
    end
  end

  // ---------------------------------------------------------------
  // control storage
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 14; g++) begin : g_touch
      always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
          touch_reg[g] <= PRM_CTRL_RESET;
        end else if (write_touch && addr_reg == 6'(g)) begin
          touch_reg[g] <= word_i; // R6
        end
      end
    end
    for (g = 0; g < 40; g++) begin : g_audio
      always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
          audio_reg[g] <= PRM_CTRL_RESET;
        end else if (write_audio && addr_reg == 6'(g)) begin
          audio_reg[g] <= word_i; // R8
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // read output
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      read_word_reg <= 16'h0000;
      read_valid_reg <= 1'b0;
      pop_reg <= 1'b0;
    end else begin
      read_valid_reg <= read_now;
      pop_reg <= read_now && acc_page == PRM_PAGE_BUFFER && !acc_past;
      if (read_now) begin
        read_word_reg <= rd_mux;
      end
    end
  end

  assign read_word_o = read_word_reg;
  assign read_valid_o = read_valid_reg;
  assign buffer_pop_o = pop_reg;
  assign touch_setting_o = touch_reg;
  assign audio_setting_o = audio_reg;
endmodule : prm_register_map
`default_nettype wire

// *** rtl/prm_pkg.sv ***
/*
  prm_pkg: constants for the paged register map of the touch and audio controller.
  Assumes a 16-bit command word and 16-bit data words on the register port.
*/
package prm_pkg;
  // ---------------------------------------------------------------
  // command word layout
  // ---------------------------------------------------------------
  localparam int PRM_CMD_DIR_BIT = 15;
  localparam int PRM_CMD_PAGE_LSB = 11;
  localparam int PRM_CMD_ADDR_LSB = 5;
  localparam logic [4:0] PRM_CMD_PAD = 5'h00;
  // ---------------------------------------------------------------
  // pages and addresses
  // ---------------------------------------------------------------
  localparam logic [3:0] PRM_PAGE_DATA = 4'h0;
  localparam logic [3:0] PRM_PAGE_TOUCH = 4'h1;
  localparam logic [3:0] PRM_PAGE_AUDIO = 4'h2;
  localparam logic [3:0] PRM_PAGE_BUFFER = 4'h3;
  localparam logic [5:0] PRM_ADDR_HORIZONTAL = 6'h00;
  localparam logic [5:0] PRM_ADDR_VERTICAL = 6'h01;
  localparam logic [5:0] PRM_ADDR_PRESSURE_FIRST = 6'h02;
  localparam logic [5:0] PRM_ADDR_PRESSURE_SECOND = 6'h03;
  localparam logic [5:0] PRM_ADDR_BATTERY = 6'h05;
  localparam logic [5:0] PRM_ADDR_AUX_ONE = 6'h07;
  localparam logic [5:0] PRM_ADDR_AUX_TWO = 6'h08;
  localparam logic [5:0] PRM_ADDR_TEMP_FIRST = 6'h09;
  localparam logic [5:0] PRM_ADDR_TEMP_SECOND = 6'h0a;
  localparam logic [5:0] PRM_ADDR_TOUCH_LAST = 6'h0d;
  localparam logic [5:0] PRM_ADDR_AUDIO_LAST = 6'h27;
  localparam logic [5:0] PRM_ADDR_PAGE_LAST = 6'h3f;
  localparam int PRM_RESULT_COUNT = 9;
  localparam int PRM_RESULT_WIDTH = 12;
  // ---------------------------------------------------------------
  // reset values and read fillers
  // ---------------------------------------------------------------
  localparam logic [15:0] PRM_RESULT_RESET = 16'h0000;
  localparam logic [15:0] PRM_CTRL_RESET = 16'h0000;
  localparam logic [15:0] PRM_RESERVED_READ = 16'h0000;
  localparam logic [15:0] PRM_PAST_END_READ = 16'hffff;
  // ---------------------------------------------------------------
  // transfer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {PRM_IDLE, PRM_READ, PRM_WRITE} prm_state_t;
endpackage : prm_pkg

// *** rtl/prm_res_if.sv ***
/*
  prm_res_if: conversion result write path into the result bank and read path out of it.
  Assumes one producer (the register map top) and one consumer (the bank).
*/
`timescale 1ns/1ps
`default_nettype none
interface prm_res_if;
  logic wr_en;
  logic [3:0] wr_idx;
  logic [11:0] wr_value;
  logic [3:0] rd_idx;
  logic [15:0] rd_word;
  modport src (output wr_en, output wr_idx, output wr_value, output rd_idx, input rd_word);
  modport bank (input wr_en, input wr_idx, input wr_value, input rd_idx, output rd_word);
endinterface : prm_res_if
`default_nettype wire

// *** rtl/prm_result_bank.sv ***
/*
  prm_result_bank: nine read-only conversion result words of page 0.
  Assumes writes come only from the converter side, never from the host.
*/
`timescale 1ns/1ps
`default_nettype none
module prm_result_bank
  import prm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // result path
  prm_res_if.bank res
);
  logic [PRM_RESULT_WIDTH-1:0] value_reg [PRM_RESULT_COUNT];
  wire rd_ok = res.rd_idx < 4'(PRM_RESULT_COUNT);

  genvar g;
  generate
    for (g = 0; g < PRM_RESULT_COUNT; g++) begin : g_res
      always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
          value_reg[g] <= PRM_RESULT_RESET[PRM_RESULT_WIDTH-1:0]; // R3
        end else if (res.wr_en && res.wr_idx == 4'(g)) begin
          value_reg[g] <= res.wr_value;
        end
      end
    end
  endgenerate

  // top nibble forced low so a wide source can never leak in
  assign res.rd_word = rd_ok ? {4'h0, value_reg[res.rd_idx]} : PRM_RESERVED_READ; // R5
endmodule : prm_result_bank
`default_nettype wire

// *** bench/prm_register_map_properties.sv ***
/* checker for prm_register_map ports.
   Assumes one clock and the one-cycle word strobes of the top. */
`timescale 1ns/1ps
`default_nettype none
module prm_register_map_checker (
  // watched ports
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic frame_start_i,
  input wire logic word_valid_i,
  input wire logic [15:0] word_i,
  input wire logic [15:0] read_word_o,
  input wire logic read_valid_o,
  input wire logic buffer_pop_o,
  input wire logic [15:0] touch_status_i [14]
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // frame start wins over a same-cycle word
  wire logic tk = word_valid_i && !frame_start_i;
  property p_rd; frame_start_i ##1 (tk && word_i[15]) |=> read_valid_o; endproperty
  a_rd: assert property (p_rd) else $error("read unanswered");
  property p_wr; frame_start_i ##1 (tk && !word_i[15]) |=> !read_valid_o; endproperty
  a_wr: assert property (p_wr) else $error("write answered");
  property p_idle; !tk |=> !read_valid_o; endproperty
  a_idle: assert property (p_idle) else $error("answer without word");
  property p_pop; buffer_pop_o |-> read_valid_o; endproperty
  a_pop: assert property (p_pop) else $error("pop without read");
  property p_pg3; frame_start_i ##1 (tk && word_i[15:11] == 5'h13) |=> buffer_pop_o; endproperty
  a_pg3: assert property (p_pg3) else $error("buffer read without pop");
  property p_top; frame_start_i ##1 (tk && word_i[15:11] == 5'h10) |=> !(|read_word_o[15:12]);
  endproperty
  a_top: assert property (p_top) else $error("result top bits set");
  property p_rsv; frame_start_i ##1 (tk && word_i[15:5] == 11'h404) |=> read_word_o == 16'h0000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved result nonzero");
  property p_pg; frame_start_i ##1 (tk && word_i[15] && |word_i[14:13]) |=> read_word_o == 16'h0;
  endproperty
  a_pg: assert property (p_pg) else $error("reserved page nonzero");
  property p_st; frame_start_i ##1 (tk && word_i[15:5] == 11'h440) |=>
    read_word_o == $past(touch_status_i[0]);
  endproperty
  a_st: assert property (p_st) else $error("status not returned");
endmodule // prm_register_map_checker
bind prm_register_map prm_register_map_checker u_chk (.*);
`default_nettype wire

// *** bench/prm_host.sv ***
/* prm_host: host side of the deframed command port.
   Assumes tasks are entered just after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module prm_host
  import prm_pkg::*;
(
  // clock
  input wire logic clk_sys_i,
  // words to the device
  output logic frame_start_o,
  output logic word_valid_o,
  output logic [15:0] word_o
);
  initial begin
    frame_start_o = 1'b0;
    word_valid_o = 1'b0;
    word_o = 16'h0000;
  end
  // released data goes inverted so stale values never match
  task automatic send(input logic [15:0] w);
    word_valid_o = 1'b1;
    word_o = w;
    @(posedge clk_sys_i) #1;
    word_valid_o = 1'b0;
    word_o = ~w;
    @(posedge clk_sys_i) #1;
  endtask
  task automatic cmd(input logic rd, input logic [3:0] pg, input logic [5:0] ad);
    frame_start_o = 1'b1;
    @(posedge clk_sys_i) #1;
    frame_start_o = 1'b0;
    send({rd, pg, ad, PRM_CMD_PAD});
  endtask
  // select falling together with a word: the word must be dropped
  task automatic cut(input logic [15:0] w);
    frame_start_o = 1'b1;
    word_valid_o = 1'b1;
    word_o = w;
    @(posedge clk_sys_i) #1;
    frame_start_o = 1'b0;
    word_valid_o = 1'b0;
    word_o = ~w;
    @(posedge clk_sys_i) #1;
  endtask
endmodule // prm_host
`default_nettype wire

// *** bench/tb_top.sv ***
/* tb_top: self-checking bench for prm_register_map.
   Assumes the host model drives the command port at 25 MHz. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import prm_pkg::*;
  logic clk_sys_i, resetn_i, fs, wv, rv, pop, cv;
  logic [15:0] w, rw, bw;
  logic [3:0] ci;
  logic [11:0] cval;
  logic [15:0] st [14];
  logic [15:0] ts [14];
  logic [15:0] as [40];
  int bad_count, num_checks;
  int pops, reads;
  // row table: page 0 address to result index, -1 reads zero
  int map [16] = '{0, 1, 2, 3, -1, 4, -1, 5, 6, 7, 8, -1, -1, -1, -1, -1};
  prm_host u_host (.clk_sys_i(clk_sys_i), .frame_start_o(fs), .word_valid_o(wv), .word_o(w));
  prm_register_map u_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .frame_start_i(fs),
    .word_valid_i(wv), .word_i(w), .read_word_o(rw), .read_valid_o(rv), .conv_valid_i(cv),
    .conv_idx_i(ci), .conv_value_i(cval), .touch_status_i(st), .buffer_word_i(bw),
    .buffer_pop_o(pop), .touch_setting_o(ts), .audio_setting_o(as));
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // pulse counters for the one-cycle outputs
  always @(posedge clk_sys_i) begin
    if (pop) pops++;
    if (rv) reads++;
  end
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic sweep(input bit full);
    u_host.cmd(1'b1, PRM_PAGE_DATA, 6'h00);
    for (int a = 0; a < 16; a++) begin
      chk("page0", rw, (full && map[a] >= 0) ? {4'h0, 12'h8a0 + 12'(map[a])} : 16'h0);
      u_host.send(16'h0000);
    end
  endtask
  // ----------------
  // main sequence
  // ----------------
  initial begin
    resetn_i = 1'b0;
    cv = 1'b0;
    ci = 4'h0;
    cval = 12'h000;
    bw = 16'h3c5a;
    for (int i = 0; i < 14; i++) st[i] = 16'h5000 + 16'(i);
    repeat (16) @(posedge clk_sys_i);
    #1 resetn_i = 1'b1;
    sweep(1'b0);
    for (int i = 0; i < 9; i++) begin
      cv = 1'b1;
      ci = 4'(i);
      cval = 12'h8a0 + 12'(i);
      @(posedge clk_sys_i) #1;
    end
    cv = 1'b0;
    u_host.cmd(1'b0, PRM_PAGE_DATA, 6'h00);
    u_host.send(16'h1234);
    sweep(1'b1);
    u_host.cmd(1'b0, PRM_PAGE_TOUCH, 6'h00);
    for (int i = 0; i < 15; i++) u_host.send(16'ha000 + 16'(i));
    for (int i = 0; i < 14; i++) chk("setting", ts[i], 16'ha000 + 16'(i));
    u_host.cmd(1'b1, PRM_PAGE_TOUCH, 6'h0d);
    chk("status", rw, st[13]);
    u_host.send(16'h0000);
    chk("touch rsv", rw, 16'h0000);
    u_host.cmd(1'b0, PRM_PAGE_AUDIO, PRM_ADDR_AUDIO_LAST);
    u_host.send(16'hbeef);
    u_host.send(16'h1111);
    chk("audio", as[39], 16'hbeef);
    chk("audio low", as[0], 16'h0000);
    u_host.cmd(1'b1, PRM_PAGE_AUDIO, PRM_ADDR_AUDIO_LAST);
    chk("audio rd", rw, 16'hbeef);
    u_host.send(16'h0000);
    chk("audio rsv", rw, 16'h0000);
    pops = 0;
    reads = 0;
    u_host.cmd(1'b1, PRM_PAGE_BUFFER, PRM_ADDR_PAGE_LAST);
    chk("buffer", rw, bw);
    u_host.send(16'h0000);
    chk("past end", rw, 16'hffff);
    chk("pops", 16'(pops), 16'h0001);
    chk("reads", 16'(reads), 16'h0002);
    bw = 16'hc3a5;
    u_host.cmd(1'b1, PRM_PAGE_BUFFER, 6'h10);
    chk("buffer mid", rw, 16'hc3a5);
    chk("pops mid", 16'(pops), 16'h0002);
    u_host.cmd(1'b1, 4'h9, 6'h02);
    chk("rsv page", rw, 16'h0000);
    resetn_i = 1'b0;
    @(posedge clk_sys_i) #1;
    resetn_i = 1'b1;
    chk("setting rst", ts[0], 16'h0000);
    for (int i = 0; i < 14; i++) st[i] = 16'h6000 + 16'(i);
    u_host.cmd(1'b1, PRM_PAGE_TOUCH, 6'h00);
    chk("status new", rw, 16'h6000);
    u_host.cut(16'h0000);
    chk("cut", rw, 16'h6000);
    u_host.send({1'b1, PRM_PAGE_TOUCH, 6'h01, PRM_CMD_PAD});
    chk("after cut", rw, 16'h6001);
    u_host.cmd(1'b1, PRM_PAGE_DATA, 6'h04);
    chk("rsv result", rw, 16'h0000);
    sweep(1'b0);
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
